// >>> ppsc_top.sv
// serial control, latches, reference chain and phase logic of the synthesizer
// assumes all pins are synchronous to pclk and much slower than it
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
module ppsc_top
	import ppsc_pkg::*;
(
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// reference oscillator and standby outputs
	input wire logic ref_osc,
	output logic ctrl_clk_out,
	output logic time_tick_out,
	// three-wire serial link
	input wire logic ser_data,
	input wire logic ser_clk,
	input wire logic ser_load_n,
	// vco inputs and charge pump
	input wire logic am_in,
	input wire logic fm_in,
	input wire logic cp_enable,
	output logic cp_out,
	output logic cp_oe,
	// open-collector function outputs
	output logic [PPSC_FUNC_W-1:0] func_pull_n,
	output logic band_select
);

	// apb state
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, pslverr_ff, nxt_pslverr, synth_power_ff, apb_setup_done, apb_write;
	// serial link state
	ppsc_state_type st_ff, nxt_st;
	logic ser_clk_q_ff, load_q_ff, addr_cnt_ff, addr_first_ff, rejected_ff;
	logic [PPSC_WORD_W-1:0] shift_ff;
	logic [PPSC_DIVN_W-1:0] divide_n_ff, div_cnt_ff;
	logic [PPSC_FUNC_W-1:0] func_ff;
	logic clk_rise, load_fall, load_rise, valid_load;
	// reference chain and loop
	logic ref_q_ff, ref_rise, p25, p10, am_q_ff, fm_q_ff, vco_rise, pre_pulse;
	logic [PPSC_PRE_W-1:0] pre_ratio;
	logic div_pulse_ff, div_wrap, ref_pulse, up_ff, dn_ff, cp_out_ff, cp_oe_ff;

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign func_pull_n = func_ff;
	assign band_select = func_ff[PPSC_BAND_IDX];
	assign cp_out = cp_out_ff;
	assign cp_oe = cp_oe_ff;

	// apb: one wait state, answer registered
	assign apb_setup_done = psel && penable && !pready_ff;
	assign apb_write = psel && penable && pready_ff && pwrite;

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		nxt_pslverr = 1'b0;
		if (paddr == PPSC_ADDR_LATCH) begin
			nxt_prdata[PPSC_WORD_W-1:0] = {func_ff, divide_n_ff};
			nxt_pslverr = pwrite;
		end else if (paddr == PPSC_ADDR_STATUS) begin
			nxt_prdata[PPSC_ST_RECV_BIT] = (st_ff != PPSC_IDLE);
			nxt_prdata[PPSC_ST_REJ_BIT] = rejected_ff;
			nxt_prdata[PPSC_ST_BAND_BIT] = func_ff[PPSC_BAND_IDX];
			nxt_prdata[PPSC_ST_UP_BIT] = up_ff;
			nxt_prdata[PPSC_ST_DN_BIT] = dn_ff;
			nxt_pslverr = pwrite;
		end else if (paddr == PPSC_ADDR_CTRL) begin
			nxt_prdata[PPSC_CTRL_POWER_BIT] = synth_power_ff;
		end else begin
			nxt_pslverr = 1'b1;
		end
		if (pwrite) begin
			nxt_prdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= apb_setup_done;
			prdata_ff <= apb_setup_done ? nxt_prdata : 32'h0000_0000;
			pslverr_ff <= apb_setup_done && nxt_pslverr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			synth_power_ff <= PPSC_CTRL_POWER_RST;
		end else if (apb_write && paddr == PPSC_ADDR_CTRL) begin
			synth_power_ff <= pwdata[PPSC_CTRL_POWER_BIT];
		end
	end

	// serial link edges; pins are already synchronous to pclk
	assign clk_rise = ser_clk && !ser_clk_q_ff && !ser_load_n;
	assign load_fall = !ser_load_n && load_q_ff;
	assign load_rise = ser_load_n && !load_q_ff;
	assign valid_load = load_rise && (st_ff == PPSC_DATA);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ser_clk_q_ff <= 1'b0;
			load_q_ff <= 1'b1;
		end else begin
			ser_clk_q_ff <= ser_clk;
			load_q_ff <= ser_load_n;
		end
	end

	// a clock rise in the strobe-fall cycle is not counted; the controller
	// keeps the clock low around that edge
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			PPSC_IDLE: begin
				if (load_fall) begin
					nxt_st = PPSC_ADDR;
				end
			end
			PPSC_ADDR: begin
				if (load_rise) begin
					nxt_st = PPSC_IDLE;
				end else if (clk_rise && addr_cnt_ff) begin
					nxt_st = (addr_first_ff && ser_data) ? PPSC_DATA : PPSC_REJECT;
				end
			end
			PPSC_DATA: begin
				if (load_rise) begin
					nxt_st = PPSC_IDLE;
				end
			end
			PPSC_REJECT: begin
				if (load_rise) begin
					nxt_st = PPSC_IDLE;
				end
			end
			default: begin
				nxt_st = PPSC_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= PPSC_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_cnt_ff <= 1'b0;
			addr_first_ff <= 1'b0;
		end else if (st_ff != PPSC_ADDR) begin
			addr_cnt_ff <= 1'b0;
		end else if (clk_rise && !addr_cnt_ff) begin
			addr_cnt_ff <= 1'b1;
			addr_first_ff <= ser_data;
		end
	end

	// newest bit enters at the top so the field layout falls out directly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_ff <= PPSC_WORD_RST;
		end else if (st_ff == PPSC_DATA && clk_rise) begin
			shift_ff <= {ser_data, shift_ff[PPSC_WORD_W-1:1]};
		end
	end

	// latches move only on the strobe rise after a good address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			divide_n_ff <= '0;
			func_ff <= '0;
		end else if (valid_load) begin
			divide_n_ff <= shift_ff[PPSC_DIVN_W-1:0];
			func_ff <= shift_ff[PPSC_WORD_W-1:PPSC_DIVN_W];
		end
	end

	// a new rejection wins over the clear of a good load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rejected_ff <= 1'b0;
		end else if (st_ff == PPSC_ADDR && nxt_st == PPSC_REJECT) begin
			rejected_ff <= 1'b1;
		end else if (valid_load) begin
			rejected_ff <= 1'b0;
		end
	end

	// reference chain: not gated by synth power, it stays on standby
	assign ref_rise = ref_osc && !ref_q_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_q_ff <= 1'b0;
		end else begin
			ref_q_ff <= ref_osc;
		end
	end

	ppsc_div #(.DIV(PPSC_DIV_CTRL)) u_ctrl_div (
		.clk(pclk), .rst_n(presetn), .tick(ref_rise), .wave(ctrl_clk_out), .pulse()
	);
	// only the period pulses of the phase references are used
	ppsc_div #(.DIV(PPSC_DIV_FM)) u_fm_ref_div (
		.clk(pclk), .rst_n(presetn), .tick(ref_rise), .wave(), .pulse(p25)
	);
	ppsc_div #(.DIV(PPSC_DIV_AM)) u_am_ref_div (
		.clk(pclk), .rst_n(presetn), .tick(ref_rise), .wave(), .pulse(p10)
	);
	ppsc_div #(.DIV(PPSC_DIV_TICK)) u_tick_div (
		.clk(pclk), .rst_n(presetn), .tick(p10), .wave(time_tick_out), .pulse()
	);

	// vco path; a real vco outruns pclk, this model needs slow inputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			am_q_ff <= 1'b0;
			fm_q_ff <= 1'b0;
		end else begin
			am_q_ff <= am_in;
			fm_q_ff <= fm_in;
		end
	end

	assign vco_rise = band_select ? (fm_in && !fm_q_ff) : (am_in && !am_q_ff);
	assign pre_ratio = band_select ? PPSC_FM_PRE_HI : PPSC_AM_PRE_HI;

	ppsc_presc #(.RW(PPSC_PRE_W)) u_presc (
		.clk(pclk),
		.rst_n(presetn),
		.hold(!synth_power_ff),
		.ratio(pre_ratio),
		.vco_rise(vco_rise),
		.pulse(pre_pulse)
	);

	// divide by value plus one
	assign div_wrap = pre_pulse && (div_cnt_ff >= divide_n_ff);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_ff <= '0;
			div_pulse_ff <= 1'b0;
		end else if (!synth_power_ff) begin
			div_cnt_ff <= '0;
			div_pulse_ff <= 1'b0;
		end else begin
			div_cnt_ff <= div_wrap ? '0 : (pre_pulse ? div_cnt_ff + 1'b1 : div_cnt_ff);
			div_pulse_ff <= div_wrap;
		end
	end

	// phase-frequency detector
	assign ref_pulse = band_select ? p25 : p10;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_ff <= 1'b0;
			dn_ff <= 1'b0;
		end else if (!synth_power_ff) begin
			up_ff <= 1'b0;
			dn_ff <= 1'b0;
		end else if ((up_ff || ref_pulse) && (dn_ff || div_pulse_ff)) begin
			up_ff <= 1'b0;
			dn_ff <= 1'b0;
		end else begin
			up_ff <= up_ff || ref_pulse;
			dn_ff <= dn_ff || div_pulse_ff;
		end
	end

	// pump drives only while one side leads and the enable is high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cp_out_ff <= 1'b0;
			cp_oe_ff <= 1'b0;
		end else begin
			cp_out_ff <= up_ff;
			cp_oe_ff <= cp_enable && synth_power_ff && (up_ff != dn_ff);
		end
	end

	AST_ADDR_REJECT: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff == PPSC_REJECT && load_rise) |=> $stable(divide_n_ff) && $stable(func_ff))
		else $error("latches changed after bad address");
	AST_REJECT_STAYS: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff == PPSC_REJECT && !load_rise) |=> st_ff == PPSC_REJECT && $stable(shift_ff))
		else $error("bits taken after bad address");
	AST_SHIFT_IN: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff == PPSC_DATA && clk_rise) |=> shift_ff == {$past(ser_data), $past(shift_ff[17:1])})
		else $error("serial bit not shifted in");
	AST_LATCH_COPY: assert property (@(posedge pclk) disable iff (!presetn)
		valid_load |=> {func_ff, divide_n_ff} == $past(shift_ff))
		else $error("latches did not take shift register");
	AST_LATCH_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		!valid_load |=> $stable(divide_n_ff) && $stable(func_ff))
		else $error("latches changed before strobe rise");
	AST_DIV_N1: assert property (@(posedge pclk) disable iff (!presetn)
		(synth_power_ff && pre_pulse && div_cnt_ff == divide_n_ff) |=> div_pulse_ff && div_cnt_ff == '0)
		else $error("divider did not end at value plus one");
	AST_BAND_REF: assert property (@(posedge pclk) disable iff (!presetn)
		(synth_power_ff && !band_select && p10 && !up_ff && !dn_ff && !div_pulse_ff) |=> up_ff)
		else $error("am reference did not reach detector");
	AST_PUMP_SRC: assert property (@(posedge pclk) disable iff (!presetn)
		(up_ff && !dn_ff && cp_enable && synth_power_ff) |=> cp_oe_ff && cp_out_ff)
		else $error("pump did not source while slow");
	AST_PUMP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		!cp_enable |=> !cp_oe_ff)
		else $error("pump driven while disabled");
	AST_STANDBY_REF: assert property (@(posedge pclk) disable iff (!presetn)
		(!synth_power_ff && ref_rise) |=> ref_q_ff && !div_pulse_ff)
		else $error("standby chain stalled");
	AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
		apb_setup_done |=> pready_ff ##1 !pready_ff)
		else $error("apb answer not one wait state");

	COV_GOOD_LOAD: cover property (@(posedge pclk) disable iff (!presetn) valid_load);
	COV_REJECT: cover property (@(posedge pclk) disable iff (!presetn)
		st_ff == PPSC_REJECT && load_rise);
	COV_PUMP_UP: cover property (@(posedge pclk) disable iff (!presetn) cp_oe_ff && cp_out_ff);
	COV_FM_LOCK: cover property (@(posedge pclk) disable iff (!presetn)
		band_select && div_pulse_ff && (up_ff || p25));

endmodule : ppsc_top

// >>> ppsc_pkg.sv
// constants shared by the synthesizer control block and its helpers
// assumes a 100 MHz pclk and a 4 MHz reference oscillator sampled on it
package ppsc_pkg;

	// apb register byte offsets
	localparam logic [31:0] PPSC_ADDR_LATCH = 32'h0000_0000;
	localparam logic [31:0] PPSC_ADDR_STATUS = 32'h0000_0004;
	localparam logic [31:0] PPSC_ADDR_CTRL = 32'h0000_0008;

	// ctrl register fields and value after reset
	localparam int PPSC_CTRL_POWER_BIT = 0;
	localparam logic PPSC_CTRL_POWER_RST = 1'b1;

	// status register field positions
	localparam int PPSC_ST_RECV_BIT = 0;
	localparam int PPSC_ST_REJ_BIT = 1;
	localparam int PPSC_ST_BAND_BIT = 2;
	localparam int PPSC_ST_UP_BIT = 3;
	localparam int PPSC_ST_DN_BIT = 4;

	// serial word layout
	localparam int PPSC_WORD_W = 18;
	localparam int PPSC_DIVN_W = 13;
	localparam int PPSC_FUNC_W = 5;
	localparam int PPSC_BAND_IDX = 2;
	localparam logic [PPSC_WORD_W-1:0] PPSC_WORD_RST = 18'h0_0000;

	// reference chain ratios, counted in reference oscillator edges; the tick ratio is counted in 10 kHz am reference pulses
	localparam int PPSC_REF_OSC_HZ = 4_000_000;
	localparam int PPSC_CTRL_CLK_HZ = 500_000;
	localparam int PPSC_FM_REF_HZ = 25_000;
	localparam int PPSC_AM_REF_HZ = 10_000;
	localparam int PPSC_TICK_HZ = 50;
	localparam int PPSC_DIV_CTRL = PPSC_REF_OSC_HZ / PPSC_CTRL_CLK_HZ;
	localparam int PPSC_DIV_FM = PPSC_REF_OSC_HZ / PPSC_FM_REF_HZ;
	localparam int PPSC_DIV_AM = PPSC_REF_OSC_HZ / PPSC_AM_REF_HZ;
	localparam int PPSC_DIV_TICK = PPSC_AM_REF_HZ / PPSC_TICK_HZ;

	// dual-modulus prescaler ratios
	localparam int PPSC_PRE_W = 7;
	localparam logic [PPSC_PRE_W-1:0] PPSC_AM_PRE_LO = 7'h07;
	localparam logic [PPSC_PRE_W-1:0] PPSC_AM_PRE_HI = 7'h08;
	localparam logic [PPSC_PRE_W-1:0] PPSC_FM_PRE_LO = 7'h3F;
	localparam logic [PPSC_PRE_W-1:0] PPSC_FM_PRE_HI = 7'h40;

	typedef enum logic [3:0] {
		PPSC_IDLE = 4'h1,
		PPSC_ADDR = 4'h2,
		PPSC_DATA = 4'h4,
		PPSC_REJECT = 4'h8
	} ppsc_state_type;

endpackage : ppsc_pkg

// >>> ppsc_div.sv
// fixed ratio divider of the reference chain: square wave plus period pulse
// assumes tick is a one-cycle pulse on pclk
`timescale 1ns/1ns
module ppsc_div #(
	parameter int DIV = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// input rate and outputs
	input wire logic tick,
	output logic wave,
	output logic pulse
);
	localparam int CW = $clog2(DIV) + 1;
	localparam logic [CW-1:0] HALF_M1 = CW'(DIV / 2 - 1);

	logic [CW-1:0] cnt_ff;
	logic wave_ff;
	logic pulse_ff;
	logic wrap;

	assign wrap = tick && (cnt_ff == HALF_M1);
	assign wave = wave_ff;
	assign pulse = pulse_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (wrap) begin
			cnt_ff <= '0;
		end else if (tick) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wave_ff <= 1'b0;
			pulse_ff <= 1'b0;
		end else begin
			wave_ff <= wrap ? !wave_ff : wave_ff;
			pulse_ff <= wrap && !wave_ff;
		end
	end

	AST_DIV_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n)
		wrap |=> (wave_ff != $past(wave_ff)) && (cnt_ff == '0))
		else $error("divider did not toggle at half period");
	AST_DIV_STEADY: assert property (@(posedge clk) disable iff (!rst_n)
		!wrap |=> $stable(wave_ff) && !pulse_ff)
		else $error("divider output moved off its period");

endmodule : ppsc_div

// >>> ppsc_presc.sv
// dual-modulus prescaler model: one pulse per ratio rising vco edges
// assumes vco_rise is a one-cycle pulse and ratio changes only between cycles
`timescale 1ns/1ns
module ppsc_presc #(
	parameter int RW = 7
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic hold,
	input wire logic [RW-1:0] ratio,
	// vco edge in, divided pulse out
	input wire logic vco_rise,
	output logic pulse
);
	logic [RW-1:0] cnt_ff;
	logic pulse_ff;
	logic wrap;

	// >= so a ratio cut mid-count cannot run the counter round
	assign wrap = vco_rise && (cnt_ff >= ratio - 1'b1);
	assign pulse = pulse_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
			pulse_ff <= 1'b0;
		end else if (hold) begin
			cnt_ff <= '0;
			pulse_ff <= 1'b0;
		end else begin
			cnt_ff <= wrap ? '0 : (vco_rise ? cnt_ff + 1'b1 : cnt_ff);
			pulse_ff <= wrap;
		end
	end

	AST_PRESC_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
		(!hold && vco_rise && cnt_ff == ratio - 1'b1) |=> pulse_ff && cnt_ff == '0)
		else $error("prescaler missed its terminal count");

endmodule : ppsc_presc

// >>> ppsc_ctrl_model.sv
// serial controller model driving the three-wire load link of the synthesizer
// assumes the bench pulses start for one cycle while busy is low; half is 2 or more
`timescale 1ns/1ns
module ppsc_ctrl_model (
	// clock
	input wire logic pclk,
	// frame request, bits sent from nbits-1 down to 0
	input wire logic start,
	input wire logic [39:0] frame,
	input wire logic [5:0] nbits,
	input wire logic [2:0] half,
	output logic busy,
	// three-wire link
	output logic ser_data,
	output logic ser_clk,
	output logic ser_load_n
);
	task automatic wait_n(input int n);
		repeat (n) @(posedge pclk);
	endtask : wait_n

	// one process owns every output, so each has a single driver
	initial begin
		busy = 1'b0;
		ser_data = 1'b0;
		ser_clk = 1'b0;
		ser_load_n = 1'b1;
		forever begin
			@(posedge pclk);
			if (start && !busy) begin
				busy <= 1'b1;
				ser_load_n <= 1'b0; // clock is low before the fall
				wait_n(3); // and stays low after it
				for (int i = int'(nbits) - 1; i >= 0; i--) begin // address, data
					ser_data <= frame[i];
					wait_n(int'(half));
					ser_clk <= 1'b1;
					wait_n(int'(half));
					ser_clk <= 1'b0;
					wait_n(1);
					// hold time over: no pull on the line, so show a changed level
					ser_data <= ~frame[i];
					wait_n(int'(half) - 1);
				end
				wait_n(2);
				ser_load_n <= 1'b1;
				wait_n(3);
				busy <= 1'b0;
			end
		end
	end
endmodule : ppsc_ctrl_model

// >>> ppsc_top_tb.sv
// self-checking bench of the synthesizer control block
// drives apb, a 4 MHz reference, both vco inputs and the serial controller model
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module ppsc_top_tb;
	import ppsc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, ctrl_clk_out, time_tick_out, ser_data, ser_clk, ser_load_n;
	logic ref_osc = 1'b0;
	logic am_in = 1'b0;
	logic fm_in = 1'b0;
	logic cp_enable = 1'b0;
	logic cp_out, cp_oe, band_select, busy;
	logic [PPSC_FUNC_W-1:0] func_pull_n;
	logic start = 1'b0;
	logic [39:0] frame = 40'h0;
	logic [5:0] nbits = 6'h14;
	logic [2:0] half = 3'h2;
	logic am_run = 1'b0;
	logic fm_run = 1'b0;
	logic [4:0] ref_cnt = 5'h00;
	logic [1:0] vco_cnt = 2'h0;
	logic [17:0] cur = 18'h0;
	int miscompares = 0;
	int num_checks = 0;

	ppsc_top i_ppsc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ref_osc(ref_osc), .ctrl_clk_out(ctrl_clk_out),
		.time_tick_out(time_tick_out), .ser_data(ser_data), .ser_clk(ser_clk),
		.ser_load_n(ser_load_n), .am_in(am_in), .fm_in(fm_in), .cp_enable(cp_enable),
		.cp_out(cp_out), .cp_oe(cp_oe), .func_pull_n(func_pull_n), .band_select(band_select));
	ppsc_ctrl_model i_ppsc_ctrl_model (.pclk(pclk), .start(start), .frame(frame),
		.nbits(nbits), .half(half), .busy(busy), .ser_data(ser_data), .ser_clk(ser_clk),
		.ser_load_n(ser_load_n));

	always #5 pclk = ~pclk;

	// 25 pclk per reference period gives 4 MHz; vco toggles every third cycle
	always @(posedge pclk) begin
		ref_cnt <= (ref_cnt == 5'h18) ? 5'h00 : ref_cnt + 5'h01;
		ref_osc <= (ref_cnt < 5'h0C);
		vco_cnt <= (vco_cnt == 2'h2) ? 2'h0 : vco_cnt + 2'h1;
		if (vco_cnt == 2'h0) begin
			am_in <= am_run & ~am_in;
			fm_in <= fm_run & ~fm_in;
		end
	end

	task automatic finish_test;
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) miscompares++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// send address ad, extra filler bits, then word w so that w[0] arrives 18th from last
	task automatic send(input logic [1:0] ad, input logic [17:0] w, input int extra);
		logic [39:0] f;
		logic early;
		logic [31:0] rd;
		logic err;
		f = {8'($urandom), $urandom};
		for (int i = 0; i < 18; i++) f[17-i] = w[i];
		f[19+extra -: 2] = ad;
		frame <= f;
		nbits <= 6'(20 + extra);
		half <= 3'($urandom_range(2, 5));
		start <= 1'b1;
		@(posedge pclk);
		start <= 1'b0;
		early = 1'b0;
		for (int n = 0; n < 3000 && (busy || n < 2); n++) begin
			@(posedge pclk);
			if (ser_load_n === 1'b0 && func_pull_n !== cur[17:13]) early = 1'b1;
		end
		`CHK("early latch", 1'b0, early)
		if (ad == 2'b11) cur = w;
		`CHK("func", cur[17:13], func_pull_n)
		`CHK("band", cur[13+PPSC_BAND_IDX], band_select)
		apb(1'b0, PPSC_ADDR_LATCH, 32'h0, rd, err);
		`CHK("latch", {14'h0, cur}, rd)
		`CHK("latch err", 1'b0, err)
		apb(1'b0, PPSC_ADDR_STATUS, 32'h0, rd, err);
		`CHK("reject", ad != 2'b11, rd[PPSC_ST_REJ_BIT])
		`CHK("st band", cur[13+PPSC_BAND_IDX], rd[PPSC_ST_BAND_BIT])
		`CHK("st idle", 1'b0, rd[PPSC_ST_RECV_BIT])
	endtask : send

	// select band, run one vco fast, expect pump up (1) or down (0)
	task automatic pump(input logic fm, input logic am_on, input logic fm_on, input logic up);
		logic seen;
		logic [17:0] w;
		w = 18'($urandom);
		w[12:0] = 13'h0001;
		w[13+PPSC_BAND_IDX] = fm;
		send(2'b11, w, 0);
		am_run <= am_on;
		fm_run <= fm_on;
		cp_enable <= 1'b1;
		seen = 1'b0;
		// a stale lead may need two reference periods to clear and re-form
		for (int n = 0; n < 21000 && !seen; n++) begin
			@(posedge pclk);
			seen = (cp_oe === 1'b1 && cp_out === up);
		end
		`CHK("pump dir", 1'b1, seen)
		cp_enable <= 1'b0;
		repeat (3) @(posedge pclk);
		seen = 1'b0;
		repeat (300) begin
			@(posedge pclk);
			if (cp_oe !== 1'b0) seen = 1'b1;
		end
		`CHK("pump float", 1'b0, seen)
	endtask : pump

	initial begin
		repeat (90000) @(posedge pclk);
		miscompares++;
		finish_test();
	end

	initial begin
		logic [31:0] rd;
		logic err;
		int t;
		void'($urandom(32'hBC52));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CHK("func rst", 5'h00, func_pull_n)
		apb(1'b0, PPSC_ADDR_CTRL, 32'h0, rd, err);
		`CHK("ctrl rst", 32'h1, rd)
		apb(1'b0, 32'h0000_000C, 32'h0, rd, err);
		`CHK("unmapped err", 1'b1, err)
		apb(1'b1, PPSC_ADDR_LATCH, 32'hFFFF_FFFF, rd, err);
		`CHK("ro err", 1'b1, err)
		send(2'b11, 18'h3FFFF, 6);
		for (int a = 0; a < 3; a++) send(2'(a), 18'($urandom), 0);
		repeat (8) send(($urandom_range(0, 3) == 0) ? 2'b01 : 2'b11, 18'($urandom),
			$urandom_range(0, 5));
		// power the loop down: reference chain keeps running, pump stays off
		apb(1'b1, PPSC_ADDR_CTRL, 32'h0, rd, err);
		apb(1'b0, PPSC_ADDR_CTRL, 32'h0, rd, err);
		`CHK("ctrl off", 32'h0, rd)
		am_run <= 1'b1;
		cp_enable <= 1'b1;
		// align to the first cycle seen low after a high phase
		t = 0;
		while (ctrl_clk_out !== 1'b1 && t < 1000) begin
			@(posedge pclk);
			t++;
		end
		while (ctrl_clk_out !== 1'b0 && t < 1000) begin
			@(posedge pclk);
			t++;
		end
		`CHK("cp off", 1'b0, cp_oe)
		t = 0;
		while (ctrl_clk_out !== 1'b1 && t < 1000) begin
			@(posedge pclk);
			t++;
		end
		while (ctrl_clk_out !== 1'b0 && t < 1000) begin
			@(posedge pclk);
			t++;
		end
		`CHK("ctrl clk period", 200, t)
		apb(1'b1, PPSC_ADDR_CTRL, 32'h1, rd, err);
		pump(1'b0, 1'b1, 1'b0, 1'b0);
		pump(1'b0, 1'b0, 1'b1, 1'b1);
		pump(1'b1, 1'b0, 1'b1, 1'b0);
		pump(1'b1, 1'b1, 1'b0, 1'b1);
		`CHK("tick", 1'b0, time_tick_out)
		finish_test();
	end
endmodule : ppsc_top_tb
